// ==== rtl/sfie_pkg.sv ====
// package: constants and types of the status flags and interrupt entry block
// Overview of operation
// - ALU flag update wins over a status write to zero, nibble-carry, carry.
// - watchdog expired flag clears on power-on, low voltage, watchdog clear, sleep.
// - watchdog expired flag sets when the watchdog timer runs out.
// - sleep entered flag clears on power-on, low voltage, watchdog clear.
// - sleep entered flag sets when the sleep op executes.
// - zero flag follows whether the affecting result is all zero.
// - additions set nibble carry on carry out of low four bits.
// - subtractions write nibble carry as inverted low nibble borrow.
// - carry is msb carry out on add, inverted msb borrow on subtract.
// - four interrupt sources share one level and one vector.
// - each source has an enable; events set pending regardless of enable.
// - no hardware priority among sources; firmware decides order.
// - enabled pending requests service, accepted only at instruction end.
// - acceptance injects a call to address 001 and sets in-service latch.
// - in-service latch clears in the instruction after return from irq.
// - requests are level sensitive; the handler clears its pending flag.
// - irq entry pushes the return address on the ten bit five deep stack.
// - return from irq reloads pc from stack top and pops it.
package sfie_pkg;

    localparam int SFIE_DATA_W = 8;
    localparam int SFIE_ADDR_W = 8;
    localparam int SFIE_PC_W = 10;
    localparam int SFIE_NUM_IRQ = 4;
    localparam int SFIE_STACK_DEPTH = 5;

    // register offsets on the file port
    localparam logic [7:0] SFIE_ADDR_STATUS = 8'h00;
    localparam logic [7:0] SFIE_ADDR_IRQ_PEND = 8'h01;
    localparam logic [7:0] SFIE_ADDR_IRQ_EN = 8'h02;

    // status field positions
    localparam int SFIE_BIT_WDT_EXP = 4;
    localparam int SFIE_BIT_SLEEP = 3;
    localparam int SFIE_BIT_ZERO = 2;
    localparam int SFIE_BIT_NIB_CARRY = 1;
    localparam int SFIE_BIT_CARRY = 0;

    localparam logic [7:0] SFIE_STATUS_RST = 8'h00;
    localparam logic [3:0] SFIE_IRQ_RST = 4'h0;
    localparam logic [9:0] SFIE_IRQ_VECTOR = 10'h001;
    localparam logic [9:0] SFIE_PC_RST = 10'h000;

    typedef enum logic [1:0] {
        SFIE_ALU_NONE,
        SFIE_ALU_LOGIC,
        SFIE_ALU_ADD,
        SFIE_ALU_SUB
    } sfie_alu_e;

    typedef struct packed {
        sfie_alu_e kind;
        logic [7:0] opa;
        logic [7:0] opb;
        logic [7:0] logic_res;
    } sfie_alu_s;

endpackage : sfie_pkg

// ==== rtl/sfie_ret_stack.sv ====
// return address stack: flip-flop storage, wraps when over-pushed
`timescale 1ns/1ps
`default_nettype none
module sfie_ret_stack
    import sfie_pkg::*;
#(
    parameter int DEPTH = SFIE_STACK_DEPTH,
    parameter int WIDTH = SFIE_PC_W
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // stack operations
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [WIDTH-1:0] push_data_i,
    output logic [WIDTH-1:0] top_o
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W-1:0] PTR_MAX = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W-1:0] PTR_ZERO = '0;
    localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

    logic [WIDTH-1:0] entry_ff [DEPTH];
    logic [PTR_W-1:0] ptr_ff;
    logic [PTR_W-1:0] top_idx;

    // overflow silently overwrites the oldest entry, like a call chain too deep
    assign top_idx = (ptr_ff == PTR_ZERO) ? PTR_MAX : ptr_ff - PTR_ONE;
    assign top_o = entry_ff[top_idx];

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ptr_ff <= PTR_ZERO;
        end
        else if (push_i)
        begin
            ptr_ff <= (ptr_ff == PTR_MAX) ? PTR_ZERO : ptr_ff + PTR_ONE;
        end
        else if (pop_i)
        begin
            ptr_ff <= top_idx;
        end
    end

    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        always_ff @(posedge clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
            begin
                entry_ff[i] <= '0;
            end
            else if (push_i && (ptr_ff == PTR_W'(i)))
            begin
                entry_ff[i] <= push_data_i;
            end
        end
    end

endmodule : sfie_ret_stack
`default_nettype wire

// ==== rtl/sfie_top.sv ====
// status flags register and single-vector interrupt entry
`timescale 1ns/1ps
`default_nettype none
module sfie_top
    import sfie_pkg::*;
#(
    parameter int NUM_IRQ = SFIE_NUM_IRQ,
    parameter int STACK_DEPTH = SFIE_STACK_DEPTH
)
(
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    // pin or watchdog reset, synchronous pulse
    input wire logic SOFT_RST_I,

    // file register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,

    // alu operation of the current instruction
    input wire sfie_alu_s ALU_I,

    // instruction pipeline events
    input wire logic INSTR_END_I,
    input wire logic OP_CALL_I,
    input wire logic OP_RET_I,
    input wire logic OP_RETURN_FROM_IRQ_OP_I,
    input wire logic OP_SLEEP_I,
    input wire logic OP_WDT_CLEAR_I,
    input wire logic WDT_EXPIRE_I,
    input wire logic [9:0] PC_NEXT_I,

    // interrupt sources
    input wire logic [NUM_IRQ-1:0] IRQ_EVENT_I,

    // to the core
    output logic [7:0] FLAGS_O,
    output logic IRQ_REQ_O,
    output logic IN_SERVICE_O,
    output logic IRQ_TAKE_O,
    output logic PC_LOAD_O,
    output logic [9:0] PC_LOAD_ADDR_O
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic wdt_exp_ff;
    logic sleep_ff;
    logic zero_ff;
    logic nib_carry_ff;
    logic carry_ff;

    logic [NUM_IRQ-1:0] irq_pend_ff;
    logic [NUM_IRQ-1:0] irq_en_ff;
    logic in_service_ff;
    logic return_from_irq_op_seen_ff;

    logic [7:0] rdata_ff;
    logic [7:0] flags_ff;
    logic irq_req_ff;
    logic irq_take_ff;
    logic pc_load_ff;
    logic [9:0] pc_load_addr_ff;

    logic [7:0] status_view;
    logic wr_status;
    logic wr_pend;
    logic wr_en;

    logic [8:0] add_full;
    logic [4:0] add_low;
    logic [8:0] sub_full;
    logic [4:0] sub_low;
    logic [7:0] alu_res;
    logic alu_hits_zero;
    logic alu_hits_carry;

    logic nxt_zero;
    logic nxt_nib_carry;
    logic nxt_carry;

    logic irq_active;
    logic latch_release;
    logic branch_now;
    logic irq_accept;
    logic stack_push;
    logic stack_pop;
    logic [9:0] stack_top;

    ////////////////////////////////////////////////////////////////////////
    // register port decode

    assign wr_status = REG_WR_I && (REG_ADDR_I == SFIE_ADDR_STATUS);
    assign wr_pend = REG_WR_I && (REG_ADDR_I == SFIE_ADDR_IRQ_PEND);
    assign wr_en = REG_WR_I && (REG_ADDR_I == SFIE_ADDR_IRQ_EN);

    assign status_view = {3'h0, wdt_exp_ff, sleep_ff, zero_ff, nib_carry_ff, carry_ff};

    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            rdata_ff <= 8'h00;
        end
        else if (REG_RD_I)
        begin
            case (REG_ADDR_I)
                SFIE_ADDR_STATUS: rdata_ff <= status_view;
                SFIE_ADDR_IRQ_PEND: rdata_ff <= 8'(irq_pend_ff);
                SFIE_ADDR_IRQ_EN: rdata_ff <= 8'(irq_en_ff);
                default: rdata_ff <= 8'h00;
            endcase
        end
        else
        begin
            // data stand only in the cycle after the read strobe
            rdata_ff <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alu flag computation

    assign add_full = {1'b0, ALU_I.opa} + {1'b0, ALU_I.opb};
    assign add_low = {1'b0, ALU_I.opa[3:0]} + {1'b0, ALU_I.opb[3:0]};
    assign sub_full = {1'b0, ALU_I.opa} - {1'b0, ALU_I.opb};
    assign sub_low = {1'b0, ALU_I.opa[3:0]} - {1'b0, ALU_I.opb[3:0]};

    always_comb
    begin
        case (ALU_I.kind)
            SFIE_ALU_ADD: alu_res = add_full[7:0];
            SFIE_ALU_SUB: alu_res = sub_full[7:0];
            default: alu_res = ALU_I.logic_res;
        endcase
    end

    assign alu_hits_zero = (ALU_I.kind != SFIE_ALU_NONE);
    assign alu_hits_carry = (ALU_I.kind == SFIE_ALU_ADD) || (ALU_I.kind == SFIE_ALU_SUB);

    always_comb
    begin
        nxt_zero = zero_ff;
        nxt_nib_carry = nib_carry_ff;
        nxt_carry = carry_ff;
        if (wr_status && !alu_hits_zero)
        begin
            nxt_zero = REG_WDATA_I[SFIE_BIT_ZERO];
            nxt_nib_carry = REG_WDATA_I[SFIE_BIT_NIB_CARRY];
            nxt_carry = REG_WDATA_I[SFIE_BIT_CARRY];
        end
        if (alu_hits_zero)
        begin
            nxt_zero = (alu_res == 8'h00);
        end
        case (ALU_I.kind)
            SFIE_ALU_ADD:
            begin
                nxt_nib_carry = add_low[4];
                nxt_carry = add_full[8];
            end
            SFIE_ALU_SUB:
            begin
                nxt_nib_carry = ~sub_low[4];
                nxt_carry = ~sub_full[8];
            end
            default:
            begin
                // logic ops leave both carries alone
                nxt_nib_carry = nxt_nib_carry;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // arithmetic flags

    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            zero_ff <= SFIE_STATUS_RST[SFIE_BIT_ZERO];
            nib_carry_ff <= SFIE_STATUS_RST[SFIE_BIT_NIB_CARRY];
            carry_ff <= SFIE_STATUS_RST[SFIE_BIT_CARRY];
        end
        else if (SOFT_RST_I)
        begin
            zero_ff <= SFIE_STATUS_RST[SFIE_BIT_ZERO];
            nib_carry_ff <= SFIE_STATUS_RST[SFIE_BIT_NIB_CARRY];
            carry_ff <= SFIE_STATUS_RST[SFIE_BIT_CARRY];
        end
        else
        begin
            zero_ff <= nxt_zero;
            nib_carry_ff <= nxt_nib_carry;
            carry_ff <= nxt_carry;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset cause flags, read only, untouched by pin or watchdog reset

    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            wdt_exp_ff <= SFIE_STATUS_RST[SFIE_BIT_WDT_EXP];
        end
        else if (WDT_EXPIRE_I)
        begin
            wdt_exp_ff <= 1'b1;
        end
        else if (OP_WDT_CLEAR_I || OP_SLEEP_I)
        begin
            wdt_exp_ff <= 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            sleep_ff <= SFIE_STATUS_RST[SFIE_BIT_SLEEP];
        end
        else if (OP_SLEEP_I)
        begin
            sleep_ff <= 1'b1;
        end
        else if (OP_WDT_CLEAR_I)
        begin
            sleep_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt pending and enable, one slice per source

    for (genvar i = 0; i < NUM_IRQ; i++)
    begin : g_src
        always_ff @(posedge MCLK_I or negedge RESETN_I)
        begin
            if (!RESETN_I)
            begin
                irq_pend_ff[i] <= SFIE_IRQ_RST[i];
            end
            else if (IRQ_EVENT_I[i])
            begin
                irq_pend_ff[i] <= 1'b1;
            end
            else if (SOFT_RST_I)
            begin
                irq_pend_ff[i] <= SFIE_IRQ_RST[i];
            end
            else if (wr_pend && REG_WDATA_I[i])
            begin
                irq_pend_ff[i] <= 1'b0;
            end
        end

        always_ff @(posedge MCLK_I or negedge RESETN_I)
        begin
            if (!RESETN_I)
            begin
                irq_en_ff[i] <= SFIE_IRQ_RST[i];
            end
            else if (SOFT_RST_I)
            begin
                irq_en_ff[i] <= SFIE_IRQ_RST[i];
            end
            else if (wr_en)
            begin
                irq_en_ff[i] <= REG_WDATA_I[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt entry

    assign irq_active = |(irq_pend_ff & irq_en_ff);

    assign latch_release = INSTR_END_I && return_from_irq_op_seen_ff && !OP_RETURN_FROM_IRQ_OP_I;

    // an instruction that moves the stack itself cannot share its end with an entry
    assign branch_now = OP_CALL_I || OP_RET_I || OP_RETURN_FROM_IRQ_OP_I;

    assign irq_accept = INSTR_END_I && irq_active && !branch_now
                        && !SOFT_RST_I && (!in_service_ff || latch_release);

    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            return_from_irq_op_seen_ff <= 1'b0;
        end
        else if (SOFT_RST_I)
        begin
            return_from_irq_op_seen_ff <= 1'b0;
        end
        else if (OP_RETURN_FROM_IRQ_OP_I)
        begin
            return_from_irq_op_seen_ff <= 1'b1;
        end
        else if (INSTR_END_I)
        begin
            return_from_irq_op_seen_ff <= 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            in_service_ff <= 1'b0;
        end
        else if (SOFT_RST_I)
        begin
            in_service_ff <= 1'b0;
        end
        else if (irq_accept)
        begin
            in_service_ff <= 1'b1;
        end
        else if (latch_release)
        begin
            in_service_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // return stack

    assign stack_push = irq_accept || (OP_CALL_I && !SOFT_RST_I);
    assign stack_pop = (OP_RET_I || OP_RETURN_FROM_IRQ_OP_I) && !SOFT_RST_I;

    sfie_ret_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(SFIE_PC_W)
    ) u_stack (
        .clk_i(MCLK_I),
        .rst_n_i(RESETN_I),
        .push_i(stack_push),
        .pop_i(stack_pop),
        .push_data_i(PC_NEXT_I),
        .top_o(stack_top)
    );

    ////////////////////////////////////////////////////////////////////////
    // pc load and injected call

    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            pc_load_ff <= 1'b0;
            pc_load_addr_ff <= SFIE_PC_RST;
            irq_take_ff <= 1'b0;
        end
        else if (irq_accept)
        begin
            pc_load_ff <= 1'b1;
            pc_load_addr_ff <= SFIE_IRQ_VECTOR;
            irq_take_ff <= 1'b1;
        end
        else if (stack_pop)
        begin
            pc_load_ff <= 1'b1;
            pc_load_addr_ff <= stack_top;
            irq_take_ff <= 1'b0;
        end
        else
        begin
            pc_load_ff <= 1'b0;
            irq_take_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered views for the core

    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            flags_ff <= SFIE_STATUS_RST;
            irq_req_ff <= 1'b0;
        end
        else
        begin
            // one cycle behind the flags themselves
            flags_ff <= status_view;
            irq_req_ff <= irq_active && !in_service_ff;
        end
    end

    assign REG_RDATA_O = rdata_ff;
    assign FLAGS_O = flags_ff;
    assign IRQ_REQ_O = irq_req_ff;
    assign IN_SERVICE_O = in_service_ff;
    assign IRQ_TAKE_O = irq_take_ff;
    assign PC_LOAD_O = pc_load_ff;
    assign PC_LOAD_ADDR_O = pc_load_addr_ff;

endmodule : sfie_top
`default_nettype wire

// ==== sim/sfie_core_model.sv ====
// partner: instruction pipeline model pacing instruction ends and tracking the pc
`timescale 1ns/1ps
`default_nettype none
module sfie_core_model
    import sfie_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // op of the ending instruction: 1 call 2 ret 3 return_from_irq_op 4 sleep 5 watchdog clear
    input wire logic [2:0] op_i,
    // redirect from the block
    input wire logic pc_load_i,
    input wire logic [9:0] pc_load_addr_i,
    // to the block
    output logic instr_end_o,
    output logic call_o,
    output logic ret_o,
    output logic return_from_irq_op_o,
    output logic sleep_o,
    output logic wdt_clear_o,
    output logic [9:0] pc_next_o
);
    logic phase_ff;
    logic [9:0] pc_ff;
    // instruction clock is half the system clock
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase_ff <= 1'b0;
        else
            phase_ff <= !phase_ff;
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pc_ff <= SFIE_PC_RST;
        else if (pc_load_i)
            pc_ff <= pc_load_addr_i;
        else if (phase_ff)
            pc_ff <= pc_ff + 10'h001;
    end
    assign instr_end_o = phase_ff;
    // op strobes only beside an instruction end, so a strobe never lands mid-instruction
    assign call_o = phase_ff && op_i == 3'd1;
    assign ret_o = phase_ff && op_i == 3'd2;
    assign return_from_irq_op_o = phase_ff && op_i == 3'd3;
    assign sleep_o = phase_ff && op_i == 3'd4;
    assign wdt_clear_o = phase_ff && op_i == 3'd5;
    assign pc_next_o = pc_ff + 10'h001;
endmodule : sfie_core_model
`default_nettype wire

// ==== sim/sfie_top_properties.sv ====
// checker: port-level timing properties of the status flags and interrupt entry block
`timescale 1ns/1ps
`default_nettype none
module sfie_top_properties
    import sfie_pkg::*;
#(
    parameter int NUM_IRQ = SFIE_NUM_IRQ
)
(
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic SOFT_RST_I,
    // file register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    // alu and pipeline
    input wire sfie_alu_s ALU_I,
    input wire logic INSTR_END_I,
    input wire logic OP_CALL_I,
    input wire logic OP_RET_I,
    input wire logic OP_RETURN_FROM_IRQ_OP_I,
    input wire logic OP_SLEEP_I,
    input wire logic OP_WDT_CLEAR_I,
    input wire logic WDT_EXPIRE_I,
    input wire logic [9:0] PC_NEXT_I,
    input wire logic [NUM_IRQ-1:0] IRQ_EVENT_I,
    // block outputs
    input wire logic [7:0] FLAGS_O,
    input wire logic IRQ_REQ_O,
    input wire logic IN_SERVICE_O,
    input wire logic IRQ_TAKE_O,
    input wire logic PC_LOAD_O,
    input wire logic [9:0] PC_LOAD_ADDR_O
);
//////////////////////////////
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);

    logic [8:0] sum;
    logic [4:0] nib;
    logic [2:0] exp_add;
    logic [2:0] exp_sub;
    logic quiet;
    logic st_rd;
    assign sum = {1'b0, ALU_I.opa} + {1'b0, ALU_I.opb};
    assign nib = {1'b0, ALU_I.opa[3:0]} + {1'b0, ALU_I.opb[3:0]};
    assign exp_add = {sum[7:0] == 8'h00, nib[4], sum[8]};
    assign exp_sub = {ALU_I.opa == ALU_I.opb, ALU_I.opa[3:0] >= ALU_I.opb[3:0],
        ALU_I.opa >= ALU_I.opb};
    // nothing that moves the reset flags this cycle
    assign quiet = !(WDT_EXPIRE_I || OP_SLEEP_I || OP_WDT_CLEAR_I);
    assign st_rd = REG_RD_I && REG_ADDR_I == SFIE_ADDR_STATUS && !SOFT_RST_I;

    sequence s_entry;
        PC_LOAD_O && PC_LOAD_ADDR_O == SFIE_IRQ_VECTOR && IN_SERVICE_O ##1 !IRQ_TAKE_O;
    endsequence
    sequence s_return_from_irq_op;
        INSTR_END_I && OP_RETURN_FROM_IRQ_OP_I && !SOFT_RST_I;
    endsequence
//////////////////////////////
    a_add_flags:
    assert property ((ALU_I.kind == SFIE_ALU_ADD && !SOFT_RST_I) |-> ##2
        FLAGS_O[2:0] == $past(exp_add, 2)) else $error("add flags wrong");
    a_sub_flags:
    assert property ((ALU_I.kind == SFIE_ALU_SUB && !SOFT_RST_I) |-> ##2
        FLAGS_O[2:0] == $past(exp_sub, 2)) else $error("sub flags wrong");
    a_logic_zero:
    assert property ((ALU_I.kind == SFIE_ALU_LOGIC && !SOFT_RST_I) |-> ##2
        FLAGS_O[2] == ($past(ALU_I.logic_res, 2) == 8'h00)) else $error("zero flag wrong");
    a_status_read:
    assert property (st_rd |=> REG_RDATA_O == {3'b000, FLAGS_O[4:0]})
        else $error("status read wrong");
    a_ro_bits:
    assert property ((REG_WR_I && REG_ADDR_I == SFIE_ADDR_STATUS && quiet) |-> ##2
        FLAGS_O[4:3] == $past(FLAGS_O[4:3])) else $error("read-only bits written");
    a_wdt_set:
    assert property (WDT_EXPIRE_I |-> ##2 FLAGS_O[4]) else $error("expired flag not set");
    a_wdt_clear:
    assert property ((OP_WDT_CLEAR_I && !OP_SLEEP_I && !WDT_EXPIRE_I) |-> ##2
        FLAGS_O[4:3] == 2'b00) else $error("watchdog clear missed");
    a_sleep_set:
    assert property ((OP_SLEEP_I && !WDT_EXPIRE_I) |-> ##2 FLAGS_O[4:3] == 2'b01)
        else $error("sleep flags wrong");
    a_take_entry:
    assert property (IRQ_TAKE_O |-> s_entry) else $error("entry call wrong");
    a_take_at_end:
    assert property (IRQ_TAKE_O |-> $past(INSTR_END_I) && !$past(OP_RETURN_FROM_IRQ_OP_I))
        else $error("entry off instruction end");
    a_return_from_irq_op_hold:
    assert property ((IN_SERVICE_O ##0 s_return_from_irq_op) |=> PC_LOAD_O && IN_SERVICE_O && !IRQ_TAKE_O)
        else $error("return handling wrong");
    a_release_end:
    assert property (($fell(IN_SERVICE_O) && !$past(SOFT_RST_I)) |-> $past(INSTR_END_I))
        else $error("latch freed off instruction end");
    a_req_blocked:
    assert property ((IN_SERVICE_O && $past(IN_SERVICE_O)) |-> !IRQ_REQ_O)
        else $error("request while in service");
endmodule : sfie_top_properties

bind sfie_top sfie_top_properties #(.NUM_IRQ(NUM_IRQ)) sfie_top_properties_i (.*);
`default_nettype wire

// ==== sim/sfie_top_tb.sv ====
// testbench: random and corner-case checks of the status flags and interrupt entry block
`timescale 1ns/1ps
`default_nettype none
module sfie_top_tb;
    import sfie_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_rst = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic wdt_exp = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [3:0] irq_ev = 4'h0;
    logic [2:0] op = 3'd0;
    sfie_alu_s alu = '0;
    logic [7:0] rdata, flags, d;
    logic iend, call, ret, return_from_irq_op, slp, wclr, req, insvc, take, pcld;
    logic [9:0] pcn, pcla, p;
    logic [2:0] fl;
    sfie_alu_s a;
    int num_errors = 0;
    int checked = 0;
    int n;

    always #4 mclk = !mclk;

    sfie_top sfie_top_i (.MCLK_I(mclk), .RESETN_I(rst_n), .SOFT_RST_I(soft_rst),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .ALU_I(alu), .INSTR_END_I(iend), .OP_CALL_I(call),
        .OP_RET_I(ret), .OP_RETURN_FROM_IRQ_OP_I(return_from_irq_op), .OP_SLEEP_I(slp), .OP_WDT_CLEAR_I(wclr),
        .WDT_EXPIRE_I(wdt_exp), .PC_NEXT_I(pcn), .IRQ_EVENT_I(irq_ev), .FLAGS_O(flags),
        .IRQ_REQ_O(req), .IN_SERVICE_O(insvc), .IRQ_TAKE_O(take), .PC_LOAD_O(pcld),
        .PC_LOAD_ADDR_O(pcla));
    sfie_core_model sfie_core_model_i (.clk_i(mclk), .rst_n_i(rst_n), .op_i(op),
        .pc_load_i(pcld), .pc_load_addr_i(pcla), .instr_end_o(iend), .call_o(call),
        .ret_o(ret), .return_from_irq_op_o(return_from_irq_op), .sleep_o(slp), .wdt_clear_o(wclr), .pc_next_o(pcn));
//////////////////////////////
    task conclude;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    task chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task reg_wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= ad;
        wdata <= dt;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe
    task reg_rd(input logic [7:0] ad, output logic [7:0] dt);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= ad;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        dt = rdata;
    endtask : reg_rd

    task pulse_wdt;
        @(posedge mclk);
        wdt_exp <= 1'b1;
        @(posedge mclk);
        wdt_exp <= 1'b0;
    endtask : pulse_wdt

    task do_op(input logic [2:0] o);
        @(posedge mclk);
        op <= o;
        @(negedge mclk);
        while (!iend) @(negedge mclk);
        @(posedge mclk);
        op <= 3'd0;
    endtask : do_op

    // pushed return address is the pc seen just before the entry edge
    task wait_take;
        n = 0;
        @(negedge mclk);
        while (take !== 1'b1 && n < 40)
        begin
            p = pcn;
            n++;
            @(negedge mclk);
        end
        chk("entry call address", SFIE_IRQ_VECTOR, pcla);
        chk("in service", 10'h001, {9'h000, insvc});
    endtask : wait_take

    function automatic logic [2:0] exp_flags(input sfie_alu_s x, input logic [2:0] old);
        logic [8:0] sm;
        logic [4:0] nb;
        sm = {1'b0, x.opa} + {1'b0, x.opb};
        nb = {1'b0, x.opa[3:0]} + {1'b0, x.opb[3:0]};
        case (x.kind)
            SFIE_ALU_ADD: exp_flags = {sm[7:0] == 8'h00, nb[4], sm[8]};
            SFIE_ALU_SUB: exp_flags = {x.opa == x.opb, x.opa[3:0] >= x.opb[3:0], x.opa >= x.opb};
            SFIE_ALU_LOGIC: exp_flags = {x.logic_res == 8'h00, old[1:0]};
            default: exp_flags = old;
        endcase
    endfunction : exp_flags
//////////////////////////////
    initial
    begin
        #100000;
        num_errors++;
        conclude();
    end

    initial
    begin
        void'($urandom(66856));
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        reg_rd(SFIE_ADDR_STATUS, d);
        chk("status reset", 10'h000, {2'b00, d});
        reg_rd(SFIE_ADDR_IRQ_PEND, d);
        chk("pending reset", 10'h000, {2'b00, d});
        reg_wr(SFIE_ADDR_STATUS, 8'hff);
        reg_rd(SFIE_ADDR_STATUS, d);
        chk("status write", 10'h007, {2'b00, d});
        fl = 3'b111;
        // corner operands first, then random ones; every fourth collides with a status write
        for (int i = 0; i < 60; i++)
        begin
            a = '{sfie_alu_e'($urandom_range(3, 1)), 8'($urandom), 8'($urandom), 8'($urandom)};
            if (i == 0) a = '{SFIE_ALU_ADD, 8'hff, 8'h01, 8'h00};
            if (i == 1) a = '{SFIE_ALU_SUB, 8'h10, 8'h01, 8'h00};
            if (i == 2) a = '{SFIE_ALU_SUB, 8'h03, 8'h05, 8'h00};
            if (i == 3) a = '{SFIE_ALU_LOGIC, 8'h00, 8'h00, 8'h00};
            @(posedge mclk);
            alu <= a;
            wr <= (i % 4 == 0);
            addr <= SFIE_ADDR_STATUS;
            wdata <= 8'($urandom);
            @(posedge mclk);
            alu.kind <= SFIE_ALU_NONE;
            wr <= 1'b0;
            fl = exp_flags(a, fl);
            reg_rd(SFIE_ADDR_STATUS, d);
            chk("alu flags", {7'h00, fl}, {2'b00, d});
        end
        pulse_wdt();
        @(posedge mclk);
        soft_rst <= 1'b1;
        @(posedge mclk);
        soft_rst <= 1'b0;
        reg_rd(SFIE_ADDR_STATUS, d);
        chk("expired kept", 10'h010, {2'b00, d});
        do_op(3'd4);
        reg_rd(SFIE_ADDR_STATUS, d);
        chk("sleep flags", 10'h008, {2'b00, d});
        pulse_wdt();
        do_op(3'd5);
        reg_rd(SFIE_ADDR_STATUS, d);
        chk("watchdog clear", 10'h000, {2'b00, d});
        for (int i = 0; i < SFIE_NUM_IRQ; i++)
        begin
            reg_wr(SFIE_ADDR_IRQ_EN, 8'h00);
            @(posedge mclk);
            irq_ev <= 4'h1 << i;
            @(posedge mclk);
            irq_ev <= 4'h0;
            reg_rd(SFIE_ADDR_IRQ_PEND, d);
            chk("pending while disabled", 10'h001 << i, {2'b00, d});
            reg_wr(SFIE_ADDR_IRQ_EN, 8'h01 << i);
            wait_take();
            repeat (3) do_op(3'd0);
            chk("no nesting", 10'h001, {9'h000, insvc});
            chk("request held off", 10'h000, {9'h000, req});
            do_op(3'd3);
            @(negedge mclk);
            chk("return address", p, pcla);
            wait_take();
            chk("one instruction between", 10'h001, 10'(n));
            reg_wr(SFIE_ADDR_IRQ_PEND, 8'h01 << i);
            do_op(3'd3);
            repeat (6) @(posedge mclk);
            chk("latch released", 10'h000, {9'h000, insvc});
        end
        pulse_wdt();
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        reg_rd(SFIE_ADDR_STATUS, d);
        chk("power-on clears", 10'h000, {2'b00, d});
        conclude();
    end
endmodule : sfie_top_tb
`default_nettype wire
